// File: rtl/rbs_sequencer.v
// Function
// - straps held 2 ms after release; device samples them inside that window
// - with eeprom loading, clocks stable within 100 ms of release on first success
// - bad eeprom load retried at most twice; third failure halts the device
// - without eeprom loading, clocks stable within 10 ms of release
// - redundancy strap picks primary or secondary; high or open is the default
// - mode straps set host interface default: 00 slave, 11 eeprom master, others reserved
`include "rbs_consts.vh"

module rbs_sequencer #(
  parameter RST_MIN_CYC = `RBS_RST_MIN_CYC,
  parameter STRAP_SAMPLE_CYC = `RBS_STRAP_SAMPLE_CYC,
  parameter EE_STABLE_CYC = `RBS_EE_STABLE_CYC,
  parameter NOEE_STABLE_CYC = `RBS_NOEE_STABLE_CYC
) (
  // clock, reset, enable
  input wire ref_clk,
  input wire rstn,
  input wire ce,
  // board pins
  input wire reset_n_pin,
  input wire [2:0] osc_freq_strap,
  input wire [1:0] host_if_mode_strap,
  input wire [1:0] bus_addr_strap,
  input wire redundancy_role_strap,
  input wire framing_standard_strap,
  // eeprom loader and pll status, same clock
  input wire ee_load_done,
  input wire ee_load_err,
  input wire pll_locked,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_q,
  // sequencer outputs
  output reg core_rst_n_q,
  output reg ee_load_start_q,
  output reg clk_out_en_q,
  output reg halted_q,
  output reg [2:0] osc_freq_q,
  output reg [1:0] bus_addr_q,
  output reg role_primary_q,
  output reg framing_q,
  output reg [1:0] host_if_cfg_q
);

  localparam [7:0] S_HOLD = 8'h01;
  localparam [7:0] S_STRAP = 8'h02;
  localparam [7:0] S_LOAD = 8'h04;
  localparam [7:0] S_WAIT_EE = 8'h08;
  localparam [7:0] S_LOCK = 8'h10;
  localparam [7:0] S_RUN = 8'h20;
  localparam [7:0] S_HALT = 8'h40;
  localparam [7:0] S_BADRST = 8'h80;

  // full-width copies, then cut to the counter widths on purpose
  localparam [31:0] RST_MIN_W = RST_MIN_CYC;
  localparam [31:0] STRAP_AT_W = STRAP_SAMPLE_CYC - 1;
  localparam [31:0] EE_LIMIT_W = EE_STABLE_CYC;
  localparam [31:0] NOEE_LIMIT_W = NOEE_STABLE_CYC;
  localparam [9:0] RST_MIN = RST_MIN_W[9:0];
  localparam [23:0] STRAP_AT = STRAP_AT_W[23:0];
  localparam [23:0] EE_LIMIT = EE_LIMIT_W[23:0];
  localparam [23:0] NOEE_LIMIT = NOEE_LIMIT_W[23:0];

  wire pin_s;
  wire [2:0] osc_s;
  wire [1:0] mode_s;
  wire [1:0] addr_s;
  wire role_s;
  wire frame_s;

  reg [7:0] state_q;
  reg [9:0] low_cnt_q;
  reg [23:0] cnt_q;
  reg [23:0] limit_q;
  reg [1:0] attempts_q;
  reg short_q;
  reg late_q;
  reg [31:0] rdata_d;

  // pin and straps pass two flops before any logic looks at them
  rbs_sync #(.W(10), .INIT(10'h000)) u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .d({reset_n_pin, osc_freq_strap, host_if_mode_strap, bus_addr_strap,
        redundancy_role_strap, framing_standard_strap}),
    .q({pin_s, osc_s, mode_s, addr_s, role_s, frame_s})
  );

  wire wr_cfg = reg_wr && (reg_addr == `RBS_REG_HOST_IF_CFG);
  wire reload = reg_wr && (reg_addr == `RBS_REG_CMD) && reg_wdata[`RBS_CMD_RELOAD_BIT];
  wire cnt_run = |(state_q & (S_STRAP | S_LOAD | S_WAIT_EE | S_LOCK));

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_HOLD;
      // power-on reset counts as a qualified reset
      low_cnt_q <= RST_MIN;
      cnt_q <= 24'h000000;
      limit_q <= 24'h000000;
      attempts_q <= 2'h0;
      short_q <= 1'b0;
      late_q <= 1'b0;
      core_rst_n_q <= 1'b0;
      ee_load_start_q <= 1'b0;
      clk_out_en_q <= 1'b0;
      halted_q <= 1'b0;
      osc_freq_q <= 3'h0;
      bus_addr_q <= 2'h0;
      role_primary_q <= `RBS_ROLE_RST;
      framing_q <= 1'b0;
      host_if_cfg_q <= `RBS_HOST_IF_CFG_RST;
    end else if (ce) begin
      if (wr_cfg)
        host_if_cfg_q <= reg_wdata[1:0];
      if (cnt_run && cnt_q != 24'hFFFFFF)
        cnt_q <= cnt_q + 24'h000001;
      if (!pin_s) begin
        // everything held while the pin is low; low time measured
        state_q <= S_HOLD;
        if (low_cnt_q != RST_MIN)
          low_cnt_q <= low_cnt_q + 10'h001;
        cnt_q <= 24'h000000;
        attempts_q <= 2'h0;
        late_q <= 1'b0;
        core_rst_n_q <= 1'b0;
        ee_load_start_q <= 1'b0;
        clk_out_en_q <= 1'b0;
        halted_q <= 1'b0;
      end else begin
        case (state_q)
          S_HOLD: begin
            low_cnt_q <= 10'h000;
            cnt_q <= 24'h000000;
            // the clock must run before release; a short pulse is no reset
            if (low_cnt_q == RST_MIN) begin
              state_q <= S_STRAP;
              short_q <= 1'b0;
              core_rst_n_q <= 1'b1;
            end else begin
              state_q <= S_BADRST;
              short_q <= 1'b1;
            end
          end
          S_STRAP: begin
            // sample halfway into the hold window
            if (cnt_q == STRAP_AT) begin
              osc_freq_q <= osc_s;
              bus_addr_q <= addr_s;
              role_primary_q <= role_s;
              framing_q <= frame_s;
              host_if_cfg_q <= mode_s;
              if (mode_s == `RBS_MODE_EE_MASTER) begin
                state_q <= S_LOAD;
                limit_q <= EE_LIMIT;
              end else begin
                state_q <= S_LOCK;
                limit_q <= NOEE_LIMIT;
              end
            end
          end
          S_LOAD: begin
            ee_load_start_q <= 1'b1;
            attempts_q <= attempts_q + 2'h1;
            state_q <= S_WAIT_EE;
          end
          S_WAIT_EE: begin
            ee_load_start_q <= 1'b0;
            // a hung load counts as a bad read once its bound has passed
            if ((ee_load_done && ee_load_err) || cnt_q >= limit_q) begin
              if (attempts_q == `RBS_MAX_ATTEMPTS) begin
                state_q <= S_HALT;
                halted_q <= 1'b1;
              end else begin
                state_q <= S_LOAD;
                limit_q <= limit_q + EE_LIMIT;
              end
            end else if (ee_load_done) begin
              state_q <= S_LOCK;
            end
          end
          S_LOCK: begin
            // outputs come up by the bound even without lock
            if (pll_locked || cnt_q >= limit_q) begin
              clk_out_en_q <= 1'b1;
              late_q <= !pll_locked;
              state_q <= S_RUN;
            end
          end
          S_RUN: begin
            if (reload && host_if_cfg_q == `RBS_MODE_EE_MASTER) begin
              state_q <= S_LOAD;
              attempts_q <= 2'h0;
              cnt_q <= 24'h000000;
              limit_q <= EE_LIMIT;
              clk_out_en_q <= 1'b0;
              late_q <= 1'b0;
            end
          end
          S_HALT: begin
            halted_q <= 1'b1;
          end
          S_BADRST: begin
            // waits for a proper low pulse on the pin
            state_q <= S_BADRST;
          end
          default: begin
            state_q <= S_HOLD;
          end
        endcase
      end
    end
  end

  // register read mux
  always @* begin
    rdata_d = 32'h00000000;
    case (reg_addr)
      `RBS_REG_HOST_IF_CFG: rdata_d[1:0] = host_if_cfg_q;
      `RBS_REG_STATUS: begin
        rdata_d[7:0] = state_q;
        rdata_d[`RBS_STS_ATT_LSB+1:`RBS_STS_ATT_LSB] = attempts_q;
        rdata_d[`RBS_STS_HALT_BIT] = halted_q;
        rdata_d[`RBS_STS_SHORT_BIT] = short_q;
        rdata_d[`RBS_STS_LATE_BIT] = late_q;
        rdata_d[`RBS_STS_STABLE_BIT] = clk_out_en_q;
      end
      `RBS_REG_STRAPS: rdata_d[9:0] = {framing_q, role_primary_q, bus_addr_q,
                                       host_if_cfg_q, osc_freq_q, 1'b0};
      default: rdata_d = 32'h00000000;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      reg_rdata_q <= 32'h00000000;
    else if (ce)
      reg_rdata_q <= reg_rd ? rdata_d : 32'h00000000;
  end

endmodule

// File: rtl/rbs_consts.vh
`ifndef RBS_CONSTS_VH
`define RBS_CONSTS_VH

// clock and timing, times in their own units
`define RBS_CLK_PERIOD_NS 100
`define RBS_RST_MIN_NS 50000
`define RBS_STRAP_HOLD_NS 2000000
`define RBS_EE_STABLE_NS 100000000
`define RBS_NOEE_STABLE_NS 10000000

// cycle counts: a least time rounds up, a longest time rounds down
`define RBS_RST_MIN_CYC ((`RBS_RST_MIN_NS + `RBS_CLK_PERIOD_NS - 1) / `RBS_CLK_PERIOD_NS)
`define RBS_STRAP_HOLD_CYC (`RBS_STRAP_HOLD_NS / `RBS_CLK_PERIOD_NS)
`define RBS_STRAP_SAMPLE_CYC (`RBS_STRAP_HOLD_CYC / 2)
`define RBS_EE_STABLE_CYC (`RBS_EE_STABLE_NS / `RBS_CLK_PERIOD_NS)
`define RBS_NOEE_STABLE_CYC (`RBS_NOEE_STABLE_NS / `RBS_CLK_PERIOD_NS)

// load attempts before the device halts
`define RBS_MAX_ATTEMPTS 2'h3

// host interface mode encodings
`define RBS_MODE_I2C_SLAVE 2'h0
`define RBS_MODE_EE_MASTER 2'h3

// register byte offsets
`define RBS_REG_HOST_IF_CFG 8'h00
`define RBS_REG_STATUS 8'h04
`define RBS_REG_STRAPS 8'h08
`define RBS_REG_CMD 8'h0C

// field positions
`define RBS_CMD_RELOAD_BIT 0
`define RBS_STS_ATT_LSB 8
`define RBS_STS_HALT_BIT 10
`define RBS_STS_SHORT_BIT 11
`define RBS_STS_LATE_BIT 12
`define RBS_STS_STABLE_BIT 13

// reset values
`define RBS_HOST_IF_CFG_RST 2'h0
`define RBS_ROLE_RST 1'h1

`endif

// File: rtl/rbs_sync.v
module rbs_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // clock and reset
  input wire ref_clk,
  input wire rstn,
  input wire ce,
  // data
  input wire [W-1:0] d,
  output wire [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          meta_q <= INIT[i];
          sync_q <= INIT[i];
        end else if (ce) begin
          meta_q <= d[i];
          sync_q <= meta_q;
        end
      end
      assign q[i] = sync_q;
    end
  endgenerate

endmodule

// File: testbench/rbs_board.sv
module rbs_board (
  // bench controls
  input wire ref_clk,
  input wire pulse,
  input wire [7:0] low_cyc,
  input wire [1:0] bad_loads,
  // device side
  input wire ee_load_start_q,
  output wire reset_n_pin,
  output logic ee_load_done = 1'b0,
  output logic ee_load_err = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rcnt_q = 8'h00;
  logic [3:0] wait_q = 4'h0;
  logic [1:0] nfail_q = 2'h0;
  // low pulse of low_cyc cycles, given only while ref_clk runs
  assign reset_n_pin = rcnt_q == 8'h00;
  always @(posedge ref_clk) begin
    ee_load_done <= 1'b0;
    // err means nothing outside done, so it wanders
    ee_load_err <= ~ee_load_err;
    if (pulse) begin
      rcnt_q <= low_cyc;
      nfail_q <= bad_loads;
    end else if (rcnt_q != 8'h00) begin
      rcnt_q <= rcnt_q - 8'h01;
    end
    if (ee_load_start_q) begin
      wait_q <= 4'hA;
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
      if (wait_q == 4'h1) begin
        ee_load_done <= 1'b1;
        ee_load_err <= nfail_q != 2'h0;
        nfail_q <= nfail_q - {1'b0, nfail_q != 2'h0};
      end
    end
  end
endmodule

// File: testbench/rbs_sequencer_monitor.sv
module rbs_sequencer_monitor #(
  parameter EE_STABLE_CYC = 1000000,
  parameter NOEE_STABLE_CYC = 100000
) (
  // clock and reset
  input wire ref_clk,
  input wire rstn,
  // watched ports
  input wire reset_n_pin,
  input wire core_rst_n_q,
  input wire ee_load_start_q,
  input wire clk_out_en_q,
  input wire halted_q,
  input wire [1:0] host_if_cfg_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  int unsigned wait_q;
  int unsigned lim;
  // cycles spent released but neither running nor halted
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wait_q <= 0;
    end else if (!core_rst_n_q || clk_out_en_q) begin
      wait_q <= 0;
    end else if (!halted_q) begin
      wait_q <= wait_q + 1;
    end
  end
  assign lim = (host_if_cfg_q == 2'h3) ? 3 * EE_STABLE_CYC + 2 : NOEE_STABLE_CYC + 2;
  property p_hold; !reset_n_pin [*4] |-> !core_rst_n_q && !clk_out_en_q && !halted_q; endproperty
  a_hold: assert property (p_hold) else $error("active while reset pin low");
  property p_rel; $rose(core_rst_n_q) |-> $past(reset_n_pin) && $past(reset_n_pin, 2); endproperty
  a_rel: assert property (p_rel) else $error("release without pin high");
  property p_pulse; ee_load_start_q |=> !ee_load_start_q; endproperty
  a_pulse: assert property (p_pulse) else $error("load start longer than a cycle");
  property p_mode; ee_load_start_q |-> host_if_cfg_q == 2'h3; endproperty
  a_mode: assert property (p_mode) else $error("load started outside master mode");
  property p_ready; ee_load_start_q |-> core_rst_n_q && !clk_out_en_q; endproperty
  a_ready: assert property (p_ready) else $error("load started at wrong time");
  property p_haltm; $rose(halted_q) |-> host_if_cfg_q == 2'h3; endproperty
  a_haltm: assert property (p_haltm) else $error("halt without loading");
  property p_haltq; halted_q |-> !clk_out_en_q && !ee_load_start_q; endproperty
  a_haltq: assert property (p_haltq) else $error("halted device active");
  property p_bound; wait_q <= lim; endproperty
  a_bound: assert property (p_bound) else $error("clocks not stable in time");
  c_run: cover property ($rose(clk_out_en_q));
  c_halt: cover property ($rose(halted_q));
  c_retry: cover property (ee_load_start_q ##[1:40] ee_load_start_q);
endmodule

bind rbs_sequencer rbs_sequencer_monitor #(
  .EE_STABLE_CYC(EE_STABLE_CYC),
  .NOEE_STABLE_CYC(NOEE_STABLE_CYC)
) u_rbs_sequencer_monitor (
  .ref_clk(ref_clk),
  .rstn(rstn),
  .reset_n_pin(reset_n_pin),
  .core_rst_n_q(core_rst_n_q),
  .ee_load_start_q(ee_load_start_q),
  .clk_out_en_q(clk_out_en_q),
  .halted_q(halted_q),
  .host_if_cfg_q(host_if_cfg_q)
);

// File: testbench/tb_rbs_sequencer.sv
module tb_rbs_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NOEE = 100;
  localparam int EE = 200;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [2:0] osc_freq_strap = 3'h5;
  logic [1:0] host_if_mode_strap = 2'h0;
  logic [1:0] bus_addr_strap = 2'h2;
  logic redundancy_role_strap = 1'b1;
  logic framing_standard_strap = 1'b1;
  logic pll_locked = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic pulse = 1'b0;
  logic [7:0] low_cyc = 8'h08;
  logic [1:0] bad_loads = 2'h0;
  wire reset_n_pin, ee_load_done, ee_load_err, core_rst_n_q, ee_load_start_q;
  wire clk_out_en_q, halted_q, role_primary_q, framing_q;
  wire [31:0] reg_rdata_q;
  wire [2:0] osc_freq_q;
  wire [1:0] bus_addr_q, host_if_cfg_q;
  int fails = 0;
  int num_checks = 0;
  int n;
  int nstart;
  logic [31:0] d;
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (ee_load_start_q === 1'b1) nstart <= nstart + 1;
  rbs_sequencer #(.RST_MIN_CYC(8), .STRAP_SAMPLE_CYC(16), .EE_STABLE_CYC(EE),
    .NOEE_STABLE_CYC(NOEE)) u_rbs_sequencer (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .reset_n_pin(reset_n_pin),
    .osc_freq_strap(osc_freq_strap),
    .host_if_mode_strap(host_if_mode_strap),
    .bus_addr_strap(bus_addr_strap),
    .redundancy_role_strap(redundancy_role_strap),
    .framing_standard_strap(framing_standard_strap),
    .ee_load_done(ee_load_done),
    .ee_load_err(ee_load_err),
    .pll_locked(pll_locked),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q),
    .core_rst_n_q(core_rst_n_q),
    .ee_load_start_q(ee_load_start_q),
    .clk_out_en_q(clk_out_en_q),
    .halted_q(halted_q),
    .osc_freq_q(osc_freq_q),
    .bus_addr_q(bus_addr_q),
    .role_primary_q(role_primary_q),
    .framing_q(framing_q),
    .host_if_cfg_q(host_if_cfg_q)
  );
  rbs_board u_rbs_board (
    .ref_clk(ref_clk),
    .pulse(pulse),
    .low_cyc(low_cyc),
    .bad_loads(bad_loads),
    .ee_load_start_q(ee_load_start_q),
    .reset_n_pin(reset_n_pin),
    .ee_load_done(ee_load_done),
    .ee_load_err(ee_load_err)
  );
  task summarize;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rd(input [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_q;
  endtask
  task wr(input [7:0] a, input [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // pulse the board reset, then wait for run or halt
  task boot(input [1:0] m, input [1:0] b, input [7:0] lo);
    @(posedge ref_clk);
    host_if_mode_strap <= m;
    bad_loads <= b;
    low_cyc <= lo;
    pulse <= 1'b1;
    @(posedge ref_clk);
    pulse <= 1'b0;
    nstart = 0;
    repeat (5) @(posedge ref_clk);
    #1 n = 5;
    while (clk_out_en_q !== 1'b1 && halted_q !== 1'b1 && n < 700) begin
      @(posedge ref_clk);
      #1 n++;
    end
  endtask
  initial begin
    #2000000 fails++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    pll_locked <= 1'b1;
    repeat (2) @(posedge ref_clk);
    boot(2'h0, 2'h0, 8'h08);
    chk(clk_out_en_q, 1'b1);
    chk(n <= 13 + NOEE, 1);
    chk({osc_freq_q, bus_addr_q, role_primary_q, framing_q, host_if_cfg_q}, 9'h16C);
    rd(8'h08);
    chk(d, {22'h0, 1'b1, 1'b1, 2'h2, 2'h0, 3'h5, 1'b0});
    rd(8'h04);
    chk(d[13:0], 14'h2020);
    @(posedge ref_clk);
    osc_freq_strap <= 3'h0;
    bus_addr_strap <= 2'h0;
    framing_standard_strap <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 chk({osc_freq_q, bus_addr_q, framing_q}, 6'h2D);
    wr(8'h00, 32'h3);
    rd(8'h00);
    chk(d, 32'h3);
    rd(8'h10);
    chk(d, 32'h0);
    // a write while the clock enable is low must not land
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(8'h00, 32'h1);
    ce <= 1'b1;
    rd(8'h00);
    chk(d, 32'h3);
    // reload command in master mode: one more load, then clocks back
    nstart = 0;
    wr(8'h0C, 32'h1);
    #1 chk(clk_out_en_q, 1'b0);
    repeat (20) @(posedge ref_clk);
    #1 chk(nstart, 1);
    chk(clk_out_en_q, 1'b1);
    @(posedge ref_clk);
    redundancy_role_strap <= 1'b0;
    boot(2'h3, 2'h2, 8'h08);
    chk(clk_out_en_q, 1'b1);
    chk(n <= 13 + 3 * EE, 1);
    chk(nstart, 3);
    chk(role_primary_q, 1'b0);
    rd(8'h04);
    chk(d[13:0], 14'h2320);
    boot(2'h3, 2'h3, 8'h08);
    chk({halted_q, clk_out_en_q}, 2'h2);
    chk(nstart, 3);
    rd(8'h04);
    chk({d[10], d[7:0]}, 9'h140);
    boot(2'h1, 2'h0, 8'h03);
    chk({core_rst_n_q, halted_q, clk_out_en_q}, 3'h0);
    rd(8'h04);
    chk({d[11], d[7:0]}, 9'h180);
    @(posedge ref_clk);
    pll_locked <= 1'b0;
    boot(2'h2, 2'h0, 8'h08);
    chk(clk_out_en_q, 1'b1);
    chk(n <= 13 + NOEE, 1);
    chk(nstart, 0);
    rd(8'h04);
    chk(d[12], 1'b1);
    summarize();
  end
endmodule
